// [rtl/timer_output_compare.sv]
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "timer_oc_defines.svh"

module timer_output_compare #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Sub clock enable
	input  wire logic              fc_tick,
	// Timer interrupt request
	output logic                   irq_req,
	// Output pin
	input  wire logic              pin_in,
	output logic                   pin_out,
	output logic                   pin_oe
);

	timer_oc_pkg::oc_state_t st;
	timer_oc_pkg::oc_state_t next_st;
	timer_oc_pkg::tick_t     ticks;
	timer_oc_pkg::level_t    levels;

	logic       src_tick;
	logic       cnt_tick;
	logic       match;
	logic       stopped;
	logic       wr;
	logic       mapped;
	logic       trst;
	logic       clk_lvl;
	logic [7:0] addr;
	logic [31:0] rdata;

	clock_divider u_div (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.fc_tick (fc_tick),
		.ticks   (ticks),
		.levels  (levels)
	);

	assign addr = paddr[7:0];

	always_comb begin
		next_st = st;
		src_tick = 1'b0;
		cnt_tick = 1'b0;
		match = 1'b0;
		trst = 1'b0;
		clk_lvl = 1'b0;
		rdata = 32'h0000_0000;
		mapped = 1'b1;
		stopped = !st.start && !st.status;
		wr = psel && penable && pwrite && st.ready;
		next_st.irq = 1'b0;

		// Count source select
		case (st.src_sel)
			2'h0: src_tick = ticks.f4;
			2'h1: src_tick = ticks.f8;
			2'h2: src_tick = ticks.f32;
			default: src_tick = ticks.fc4;
		endcase

		// Start and stop follow on the next source cycle
		if (src_tick) begin
			next_st.status = st.start;
			if (st.status) begin
				next_st.half = ~st.half;
				if (st.half) begin
					if (!st.presc_use || st.presc == `TOC_PRESC_LAST) begin
						cnt_tick = 1'b1;
					end
					if (st.presc_use) begin
						next_st.presc = st.presc + 4'h1;
					end
				end
			end
		end

		// Counter and compare match
		if (cnt_tick) begin
			if (st.counter == st.compare) begin
				next_st.counter = `TOC_COUNTER_WRAP;
				match = 1'b1;
			end else begin
				next_st.counter = st.counter + 8'h01;
			end
		end
		if (match) begin
			next_st.irq = 1'b1;
			if (st.cmp_en) begin
				next_st.cmp_level = ~st.cmp_level;
			end
		end

		// Sync watch
		if (st.start == st.status) begin
			next_st.pend = 2'h0;
		end else if (src_tick && st.pend != 2'h3) begin
			next_st.pend = st.pend + 2'h1;
		end

		// Read mux
		case (addr)
			`TOC_OFS_COUNTER: rdata[7:0] = st.counter;
			`TOC_OFS_COMPARE: rdata[7:0] = st.compare;
			`TOC_OFS_CTRL1: begin
				rdata[`TOC_C1_START] = st.start;
				rdata[`TOC_C1_STATUS] = st.status;
				rdata[`TOC_C1_HFMT] = st.hfmt;
				rdata[`TOC_C1_PM] = st.pm;
				rdata[`TOC_C1_INTSEL] = st.intsel;
			end
			`TOC_OFS_CTRL2: rdata[`TOC_C2_CMPEN] = st.cmp_en;
			`TOC_OFS_SRCSEL: begin
				rdata[`TOC_SS_SRC_MSB:`TOC_SS_SRC_LSB] = st.src_sel;
				rdata[`TOC_SS_PRESC] = st.presc_use;
			end
			`TOC_OFS_PINSEL: begin
				rdata[`TOC_PS_MODE_MSB:`TOC_PS_MODE_LSB] = st.pin_mode;
				rdata[`TOC_PS_CLK_MSB:`TOC_PS_CLK_LSB] = st.clk_sel;
				rdata[`TOC_PS_PDATA] = st.port_data;
				rdata[`TOC_PS_PDIR] = st.port_dir;
				rdata[`TOC_PS_PIN_IN] = pin_in;
			end
			default: mapped = 1'b0;
		endcase

		// APB: one wait state, answer in the second access cycle
		if (st.ready) begin
			next_st.ready = 1'b0;
			next_st.slverr = 1'b0;
		end else if (psel && penable) begin
			next_st.ready = 1'b1;
			next_st.slverr = !mapped;
			next_st.prdata = pwrite ? 32'h0000_0000 : rdata;
		end

		// Register writes
		if (wr) begin
			case (addr)
				`TOC_OFS_COMPARE: begin
					if (stopped) begin
						next_st.compare = pwdata[7:0];
					end
				end
				`TOC_OFS_CTRL1: begin
					next_st.start = pwdata[`TOC_C1_START];
					next_st.hfmt = pwdata[`TOC_C1_HFMT];
					next_st.pm = pwdata[`TOC_C1_PM];
					next_st.intsel = pwdata[`TOC_C1_INTSEL];
					trst = pwdata[`TOC_C1_TRST];
				end
				`TOC_OFS_CTRL2: next_st.cmp_en = pwdata[`TOC_C2_CMPEN];
				`TOC_OFS_SRCSEL: begin
					next_st.src_sel = pwdata[`TOC_SS_SRC_MSB:`TOC_SS_SRC_LSB];
					next_st.presc_use = pwdata[`TOC_SS_PRESC];
				end
				`TOC_OFS_PINSEL: begin
					next_st.pin_mode = pwdata[`TOC_PS_MODE_MSB:`TOC_PS_MODE_LSB];
					next_st.clk_sel = pwdata[`TOC_PS_CLK_MSB:`TOC_PS_CLK_LSB];
					next_st.port_data = pwdata[`TOC_PS_PDATA];
					next_st.port_dir = pwdata[`TOC_PS_PDIR];
				end
				default: begin
					// Counter writes dropped
					next_st.counter = next_st.counter;
				end
			endcase
		end

		// Timer reset
		if (trst) begin
			next_st.presc = 4'h0;
			next_st.counter = 8'h00;
			next_st.half = 1'b0;
			next_st.cmp_level = 1'b0;
		end

		// Pin function
		case (st.clk_sel)
			2'h0: clk_lvl = levels.f2;
			2'h1: clk_lvl = levels.fc;
			2'h2: clk_lvl = levels.f4;
			default: clk_lvl = levels.f8;
		endcase
		case (timer_oc_pkg::pin_mode_t'(st.pin_mode))
			timer_oc_pkg::PIN_CLK: begin
				next_st.pin_out = clk_lvl;
				next_st.pin_oe = 1'b1;
			end
			timer_oc_pkg::PIN_CMP: begin
				next_st.pin_out = next_st.cmp_level;
				next_st.pin_oe = 1'b1;
			end
			default: begin
				next_st.pin_out = st.port_data;
				next_st.pin_oe = st.port_dir;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.compare <= `TOC_COMPARE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.ready;
	assign pslverr = st.slverr;
	assign irq_req = st.irq;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;

	// Assertions
	logic wr_cmp;
	logic wr_cnt;
	logic wr_trst;
	assign wr_cmp = wr && addr == `TOC_OFS_COMPARE;
	assign wr_cnt = wr && addr == `TOC_OFS_COUNTER;
	assign wr_trst = wr && addr == `TOC_OFS_CTRL1 && pwdata[`TOC_C1_TRST];

	property p_wrap;
		@(posedge clk_sys) disable iff (!rst_n)
		(cnt_tick && st.counter == st.compare && !wr_trst) |=> st.counter == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.status && !wr_trst) |=> st.counter == $past(st.counter);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while stopped");

	property p_irq;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_req |-> st.counter == 8'h00 && !$past(irq_req);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without match");

	property p_toggle;
		@(posedge clk_sys) disable iff (!rst_n)
		(irq_req && $past(st.cmp_en) && !$past(wr_trst)) |-> st.cmp_level != $past(st.cmp_level);
	endproperty
	a_toggle: assert property (p_toggle) else $error("compare output not toggled");

	property p_trst_low;
		@(posedge clk_sys) disable iff (!rst_n)
		wr_trst |=> !st.cmp_level && st.counter == 8'h00 && st.presc == 4'h0;
	endproperty
	a_trst_low: assert property (p_trst_low) else $error("timer reset incomplete");

	property p_start_sync;
		@(posedge clk_sys) disable iff (!rst_n)
		(st.start && !st.status) |-> st.pend < 2'h2;
	endproperty
	a_start_sync: assert property (p_start_sync) else $error("status set too late");

	property p_stop_sync;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.start && st.status) |-> st.pend < 2'h2;
	endproperty
	a_stop_sync: assert property (p_stop_sync) else $error("status cleared too late");

	property p_cmp_lock;
		@(posedge clk_sys) disable iff (!rst_n)
		(wr_cmp && (st.start || st.status)) |=> $stable(st.compare);
	endproperty
	a_cmp_lock: assert property (p_cmp_lock) else $error("compare written while running");

	property p_cnt_ro;
		@(posedge clk_sys) disable iff (!rst_n)
		(wr_cnt && !cnt_tick) |=> $stable(st.counter);
	endproperty
	a_cnt_ro: assert property (p_cnt_ro) else $error("counter write took effect");

	property p_cmp_pin;
		@(posedge clk_sys) disable iff (!rst_n)
		(st.pin_mode == 2'h2) |=> pin_out == st.cmp_level && pin_oe;
	endproperty
	a_cmp_pin: assert property (p_cmp_pin) else $error("pin not driven by compare");

	property p_status_follow;
		@(posedge clk_sys) disable iff (!rst_n)
		src_tick |=> st.status == $past(st.start);
	endproperty
	a_status_follow: assert property (p_status_follow) else $error("status did not follow start");

	property p_level_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.status && !wr_trst) |=> $stable(st.cmp_level);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("compare output moved while stopped");

	property p_presc_idle;
		@(posedge clk_sys) disable iff (!rst_n)
		(!st.presc_use && !wr_trst) |=> $stable(st.presc);
	endproperty
	a_presc_idle: assert property (p_presc_idle) else $error("prescaler moved while unused");

	c_match: cover property (@(posedge clk_sys) disable iff (!rst_n) irq_req);
	c_start: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(st.status));
	c_cmp_wr: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_cmp && stopped);
	c_presc: cover property (@(posedge clk_sys) disable iff (!rst_n) irq_req && st.presc_use);
	c_clk_pin: cover property (@(posedge clk_sys) disable iff (!rst_n) st.pin_mode == 2'h1 && pin_oe);

endmodule // timer_output_compare

// [rtl/timer_oc_defines.svh]
`ifndef TIMER_OC_DEFINES_SVH
`define TIMER_OC_DEFINES_SVH

// Register byte offsets
`define TOC_OFS_COUNTER  8'h00
`define TOC_OFS_COMPARE  8'h04
`define TOC_OFS_CTRL1    8'h08
`define TOC_OFS_CTRL2    8'h0C
`define TOC_OFS_SRCSEL   8'h10
`define TOC_OFS_PINSEL   8'h14

// Control register 1 fields
`define TOC_C1_START     0
`define TOC_C1_STATUS    1
`define TOC_C1_TRST      2
`define TOC_C1_HFMT      3
`define TOC_C1_PM        4
`define TOC_C1_INTSEL    5

// Control register 2 fields
`define TOC_C2_CMPEN     0

// Count source select fields
`define TOC_SS_SRC_LSB   0
`define TOC_SS_SRC_MSB   1
`define TOC_SS_PRESC     2

// Output pin select fields
`define TOC_PS_MODE_LSB  0
`define TOC_PS_MODE_MSB  1
`define TOC_PS_CLK_LSB   2
`define TOC_PS_CLK_MSB   3
`define TOC_PS_PDATA     4
`define TOC_PS_PDIR      5
`define TOC_PS_PIN_IN    6

// Reset values and counts
`define TOC_COMPARE_RST  8'h00
`define TOC_PRESC_LAST   4'hF
`define TOC_COUNTER_WRAP 8'h00
`define TOC_F4_MASK      5'h03
`define TOC_F8_MASK      5'h07
`define TOC_F32_MASK     5'h1F
`define TOC_FC4_LAST     2'h3

`endif

// [rtl/timer_oc_pkg.sv]
package timer_oc_pkg;

	typedef struct packed {
		logic f4;
		logic f8;
		logic f32;
		logic fc4;
	} tick_t;

	typedef struct packed {
		logic f2;
		logic fc;
		logic f4;
		logic f8;
	} level_t;

	typedef enum logic [1:0] {PIN_PORT, PIN_CLK, PIN_CMP} pin_mode_t;

	typedef struct packed {
		logic [4:0] cnt;
		logic       fc_lvl;
		logic [1:0] fc_cnt;
		tick_t      ticks;
	} div_state_t;

	typedef struct packed {
		logic [7:0]  counter;
		logic [7:0]  compare;
		logic [3:0]  presc;
		logic        half;
		logic        start;
		logic        status;
		logic        hfmt;
		logic        pm;
		logic        intsel;
		logic        cmp_en;
		logic [1:0]  src_sel;
		logic        presc_use;
		logic [1:0]  pin_mode;
		logic [1:0]  clk_sel;
		logic        port_data;
		logic        port_dir;
		logic        cmp_level;
		logic        irq;
		logic        pin_out;
		logic        pin_oe;
		logic [31:0] prdata;
		logic        ready;
		logic        slverr;
		logic [1:0]  pend;
	} oc_state_t;

endpackage

// [rtl/clock_divider.sv]
`timescale 1ns/1ns
`include "timer_oc_defines.svh"

module clock_divider (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	// Sub clock enable
	input  wire logic                   fc_tick,
	// Rates
	output timer_oc_pkg::tick_t         ticks,
	output timer_oc_pkg::level_t        levels
);

	timer_oc_pkg::div_state_t st;
	timer_oc_pkg::div_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.cnt = st.cnt + 5'h01;
		next_st.ticks.f4 = ((st.cnt & `TOC_F4_MASK) == `TOC_F4_MASK);
		next_st.ticks.f8 = ((st.cnt & `TOC_F8_MASK) == `TOC_F8_MASK);
		next_st.ticks.f32 = (st.cnt == `TOC_F32_MASK);
		next_st.ticks.fc4 = fc_tick && (st.fc_cnt == `TOC_FC4_LAST);
		if (fc_tick) begin
			next_st.fc_lvl = ~st.fc_lvl;
			next_st.fc_cnt = st.fc_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ticks = st.ticks;
	assign levels.f2 = st.cnt[0];
	assign levels.fc = st.fc_lvl;
	assign levels.f4 = st.cnt[1];
	assign levels.f8 = st.cnt[2];

endmodule // clock_divider

// [test/pin_load.sv]
`timescale 1ns/1ns

module pin_load (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Pin from the timer
	input  wire logic pin_out,
	input  wire logic pin_oe,
	// Wire level and edge count
	output logic      pin_in,
	output int        n_edge
);
	logic last;

	// Pull-up holds the wire high when the timer releases it
	assign pin_in = pin_oe ? pin_out : 1'b1;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			last <= 1'b1;
			n_edge <= 0;
		end else begin
			last <= pin_in;
			if (pin_in !== last)
				n_edge <= n_edge + 1;
		end
	end
endmodule // pin_load

// [test/tb_top.sv]
`timescale 1ns/1ns
`include "timer_oc_defines.svh"

module tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_n;
	logic        psel, penable, pwrite;
	logic        fc_tick = 1'b0;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        pready, pslverr, errv, irq_req, pin_in, pin_out, pin_oe;
	int          n_mismatch = 0, num_checks = 0, cyc = 0, last = 0, per = 0, n_irq = 0;
	int          n_edge, t0, k, sp, n, c1, e1;
	logic [31:0] seed = 32'hDC20;

	always #5 clk_sys = ~clk_sys;

	timer_output_compare #(.ADDR_W(8)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fc_tick(fc_tick), .irq_req(irq_req),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

	pin_load u_load (.clk_sys(clk_sys), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_in(pin_in), .n_edge(n_edge));

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int exp_period(input logic pu, input int cmp, input int span);
		return (pu ? 32 : 2) * (cmp + 1) * span;
	endfunction

	function automatic int exp_edges(input int sel);
		return (sel == 0) ? 32 : (sel == 2) ? 16 : 8;
	endfunction

	// Cycle count, match pulses and their spacing
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		fc_tick <= (cyc & 3) == 0;
		if (irq_req === 1'b1) begin
			per <= cyc - last;
			last <= cyc;
			n_irq <= n_irq + 1;
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rdv = prdata;
		errv = pslverr;
		chk("pready", 1, pready);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic poll(input logic want);
		t0 = cyc;
		k = 0;
		do begin
			apb(0, `TOC_OFS_CTRL1, 0);
			k++;
		end while (rdv[`TOC_C1_STATUS] !== want && k < 40);
		chk("status", {31'h0, want}, {31'h0, rdv[`TOC_C1_STATUS]});
		chk("sync time", 1, (cyc - t0) <= 2 * sp + 12);
	endtask

	task stop_test();
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst_n = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		chk("pin after reset", 0, pin_out);
		apb(0, 8'h20, 0);
		chk("unmapped err", 1, errv);
		apb(1, `TOC_OFS_CTRL1, 32'h38);
		apb(0, `TOC_OFS_CTRL1, 0);
		chk("ctrl1 bits", 32'h38, rdv);
		for (int i = 0; i < 5; i++) begin
			sp = (i == 4) ? 16 : (i == 2) ? 32 : (i == 1) ? 8 : 4;
			n = rnd() & 32'h7;
			apb(1, `TOC_OFS_CTRL1, 32'h4);
			apb(0, `TOC_OFS_COUNTER, 0);
			chk("counter cleared", 0, rdv);
			chk("pin cleared", 0, pin_out);
			apb(1, `TOC_OFS_COMPARE, n);
			apb(0, `TOC_OFS_COMPARE, 0);
			chk("compare", n, rdv);
			apb(1, `TOC_OFS_COUNTER, 32'hFF);
			apb(0, `TOC_OFS_COUNTER, 0);
			chk("counter write", 0, rdv);
			apb(1, `TOC_OFS_SRCSEL, ((i == 3) ? 32'h4 : 32'h0) | ((i == 4) ? 32'h3 : i % 3));
			apb(1, `TOC_OFS_PINSEL, 32'h2);
			apb(1, `TOC_OFS_CTRL2, 32'h1);
			e1 = n_irq;
			apb(1, `TOC_OFS_CTRL1, 32'h1);
			poll(1'b1);
			k = 0;
			while (n_irq < e1 + 3 && k < 20000) begin
				@(posedge clk_sys);
				k++;
			end
			chk("period", exp_period(i == 3, n, sp), per);
			apb(1, `TOC_OFS_COMPARE, n ^ 8'h5);
			apb(0, `TOC_OFS_COMPARE, 0);
			chk("compare locked", n, rdv);
			apb(0, `TOC_OFS_COUNTER, 0);
			chk("counter range", 1, rdv <= n);
			apb(1, `TOC_OFS_CTRL1, 32'h0);
			poll(1'b0);
			chk("pin parity", (n_irq - e1) & 1, pin_out);
			apb(0, `TOC_OFS_COUNTER, 0);
			c1 = rdv;
			e1 = n_edge;
			repeat (40) @(posedge clk_sys);
			apb(0, `TOC_OFS_COUNTER, 0);
			chk("counter held", c1, rdv);
			chk("pin held", e1, n_edge);
			@(posedge clk_sys);
		end
		for (int j = 0; j < 4; j++) begin
			apb(1, `TOC_OFS_PINSEL, 32'h1 | (j << 2));
			repeat (4) @(posedge clk_sys);
			e1 = n_edge;
			repeat (32) @(posedge clk_sys);
			chk("clock pin edges", exp_edges(j), n_edge - e1);
		end
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		chk("pins after mid reset", 0, {pin_oe, pin_out});
		apb(0, `TOC_OFS_COMPARE, 0);
		chk("compare reset", `TOC_COMPARE_RST, rdv);
		apb(1, `TOC_OFS_PINSEL, 32'h30);
		repeat (2) @(posedge clk_sys);
		chk("port drive", 2'b11, {pin_oe, pin_out});
		apb(1, `TOC_OFS_PINSEL, 32'h0);
		apb(0, `TOC_OFS_PINSEL, 0);
		chk("port input", 2'b01, {pin_oe, rdv[`TOC_PS_PIN_IN]});
		stop_test();
	end
endmodule // tb_top
